//--- verilog/adc_cfg_regs.vh
// Register offsets, field positions, reset values and codes for the converter register bank
`ifndef ADC_CFG_REGS_VH
`define ADC_CFG_REGS_VH

`define ADDR_HI 15
`define ADDR_LO 12
`define ADDR_CONVERSION_SETUP 4'h1
`define ADDR_OUTPUT_AND_RESET_CONTROL 4'h2
`define ADDR_FAULT_FLAGS 4'h3

`define SETUP_OS_MODE_BIT 9
`define SETUP_OSR_HI 8
`define SETUP_OSR_LO 6
`define SETUP_CHECK_WRITE_BIT 5
`define SETUP_CHECK_READ_BIT 4
`define SETUP_ALERT_EN_BIT 3
`define SETUP_WIDTH_BOOST_BIT 2
`define SETUP_REF_SOURCE_BIT 1
`define SETUP_POWER_DOWN_BIT 0
`define SETUP_WRITE_MASK 12'h3FF
`define SETUP_RESET 12'h000

`define CTRL_OUTPUT_LANE_BIT 8
`define CTRL_CMD_HI 7
`define CTRL_CMD_LO 0
`define CTRL_RESET 12'h000
`define CMD_SOFT_RESET 8'h3C
`define CMD_HARD_RESET 8'hFF

`define FAULT_WRITE_CHECK_BIT 9
`define FAULT_STARTUP_LOAD_BIT 8
`define FAULT_RESET 12'h000

`define OSR_OFF 3'h0
`define OSR_MAX 3'h5

`define LOAD_CYCLES 8'h10

`endif

//--- verilog/config_loader.v
// Startup configuration load sequencer with load-failure report
`include "adc_cfg_regs.vh"

module config_loader #(
    parameter [7:0] LOAD_CYCLES = `LOAD_CYCLES
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Control
    input wire i_restart,
    input wire i_load_ok,
    // Status
    output reg o_busy,
    output reg o_done,
    output reg o_fail
);

    // ************************************************
    // Load sequence
    // ************************************************
    localparam [1:0] ST_LOAD = 2'h0;
    localparam [1:0] ST_DONE = 2'h1;

    reg [1:0] state;
    reg [7:0] count;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_LOAD;
            count <= 8'h00;
            o_busy <= 1'b1;
            o_done <= 1'b0;
            o_fail <= 1'b0;
        end else if (i_restart) begin
            state <= ST_LOAD;
            count <= 8'h00;
            o_busy <= 1'b1;
            o_done <= 1'b0;
            o_fail <= 1'b0;
        end else begin
            o_done <= 1'b0;
            o_fail <= 1'b0;
            case (state)
                ST_LOAD: begin
                    if (count == LOAD_CYCLES - 8'h01) begin
                        state <= ST_DONE;
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                        o_fail <= ~i_load_ok;
                    end else begin
                        count <= count + 8'h01;
                    end
                end
                ST_DONE: begin
                    o_busy <= 1'b0;
                end
                default: begin
                    state <= ST_LOAD;
                end
            endcase
        end
    end

endmodule // config_loader

//--- verilog/adc_config_fault_regs.v
// Configuration and fault register bank of a dual sampling converter
//
// Behaviour
// - Width boost adds two bits only when oversampling
// - Reference source bit: zero internal, one external
// - Power-down bit one puts device in shutdown
// - Address sits in top four word bits
// - Lane bit zero: both outputs; one: first
// - Soft reset clears write-check flag, flushes state, keeps registers
// - Hard reset restores every register default
// - Other command values take no reset action
// - Write-check failure flag sticky until fault read, soft reset or hard reset
// - Startup load failure sets load failure flag
// - Load failure flag cleared only by hard reset
// - Control and fault registers reset to zero
// - Ratio codes 000,110,111 disable oversampling
// - Frame with bad check code is discarded when checking is on or being switched on
`include "adc_cfg_regs.vh"

module adc_config_fault_regs #(
    parameter [7:0] LOAD_CYCLES = `LOAD_CYCLES
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst_n,
    // Register word port
    input wire i_wr_valid,
    input wire [15:0] i_wr_word,
    input wire i_wr_check_ok,
    input wire i_rd_valid,
    input wire [3:0] i_rd_addr,
    output reg [15:0] o_rd_word,
    output reg o_rd_ready,
    // Fault sources
    input wire i_load_ok,
    // Configuration outputs
    output reg o_width_boost_active,
    output reg o_reference_external,
    output reg o_shutdown,
    output reg o_oversample_enable,
    output reg [2:0] o_oversample_ratio_field,
    output reg o_serial_out_first_en,
    output reg o_serial_out_second_en,
    output reg o_soft_reset,
    output reg o_hard_reset,
    output reg o_config_busy
);

    // ************************************************
    // Reset release
    // ************************************************
    reg [1:0] rst_sync;
    wire rst_n = rst_sync[1];

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    // ************************************************
    // Decoding helpers
    // ************************************************
    function osr_active;
        input [2:0] oversample_ratio_field;
        begin
            osr_active = (oversample_ratio_field != `OSR_OFF) && (oversample_ratio_field <= `OSR_MAX);
        end
    endfunction

    function addr_hit;
        input [3:0] addr;
        input [3:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    function [15:0] frame;
        input [3:0] addr;
        input [11:0] data;
        begin
            frame = {addr, data};
        end
    endfunction

    // ************************************************
    // Register storage
    // ************************************************
    reg [11:0] setup;
    reg [11:0] ctrl;
    reg check_fail;
    reg load_fail;

    // ************************************************
    // Write decode
    // ************************************************
    wire [3:0] wr_addr = i_wr_word[`ADDR_HI:`ADDR_LO];
    wire [11:0] wr_data = i_wr_word[11:0];
    wire check_on = setup[`SETUP_CHECK_WRITE_BIT];
    // Frame is accepted unless checking is on or being switched on with a bad code
    wire enabling_check = addr_hit(wr_addr, `ADDR_CONVERSION_SETUP) &&
                          wr_data[`SETUP_CHECK_WRITE_BIT];
    wire need_check = check_on || enabling_check;
    wire wr_bad = i_wr_valid && need_check && !i_wr_check_ok;
    wire wr_ok = i_wr_valid && !wr_bad;
    wire setup_wr = wr_ok && addr_hit(wr_addr, `ADDR_CONVERSION_SETUP);
    wire ctrl_wr = wr_ok && addr_hit(wr_addr, `ADDR_OUTPUT_AND_RESET_CONTROL);
    wire [7:0] cmd = wr_data[`CTRL_CMD_HI:`CTRL_CMD_LO];
    wire soft_cmd = ctrl_wr && (cmd == `CMD_SOFT_RESET);
    wire hard_cmd = ctrl_wr && (cmd == `CMD_HARD_RESET);
    wire fault_rd = i_rd_valid && addr_hit(i_rd_addr, `ADDR_FAULT_FLAGS);

    // ************************************************
    // Startup loader
    // ************************************************
    wire load_busy;
    wire load_done;
    wire load_bad;

    config_loader #(
        .LOAD_CYCLES(LOAD_CYCLES)
    ) u_loader (
        .i_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_restart(hard_cmd),
        .i_load_ok(i_load_ok),
        .o_busy(load_busy),
        .o_done(load_done),
        .o_fail(load_bad)
    );

    // ************************************************
    // Conversion setup register
    // ************************************************
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            setup <= `SETUP_RESET;
        end else if (hard_cmd) begin
            setup <= `SETUP_RESET;
        end else if (setup_wr) begin
            setup <= wr_data & `SETUP_WRITE_MASK;
        end
    end

    // ************************************************
    // Output and reset control register
    // ************************************************
    // Only the lane bit is kept; command field is self-clearing
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `CTRL_RESET;
        end else if (hard_cmd) begin
            ctrl <= `CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl <= {3'h0, wr_data[`CTRL_OUTPUT_LANE_BIT], 8'h00};
        end
    end

    // ************************************************
    // Write-check failure flag
    // ************************************************
    // Set wins over read-clear and soft clear
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            check_fail <= 1'b0;
        end else if (hard_cmd) begin
            check_fail <= 1'b0;
        end else if (wr_bad) begin
            check_fail <= 1'b1;
        end else if (fault_rd || soft_cmd) begin
            check_fail <= 1'b0;
        end
    end

    // ************************************************
    // Startup load failure flag
    // ************************************************
    // Survives fault reads and soft reset
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_fail <= 1'b0;
        end else if (hard_cmd) begin
            load_fail <= 1'b0;
        end else if (load_done && load_bad) begin
            load_fail <= 1'b1;
        end
    end

    // ************************************************
    // Read path and outputs
    // ************************************************
    reg [11:0] rd_data;

    always @* begin
        case (i_rd_addr)
            `ADDR_CONVERSION_SETUP: rd_data = setup;
            `ADDR_OUTPUT_AND_RESET_CONTROL: rd_data = ctrl;
            `ADDR_FAULT_FLAGS: rd_data = {2'b00, check_fail, load_fail, 8'h00};
            default: rd_data = 12'h000;
        endcase
    end

    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rd_word <= 16'h0000;
            o_rd_ready <= 1'b0;
        end else begin
            o_rd_ready <= i_rd_valid;
            if (i_rd_valid) begin
                o_rd_word <= frame(i_rd_addr, rd_data);
            end
        end
    end

    // ************************************************
    // Serial lane enables
    // ************************************************
    // Lane zero always carries data; later lanes are on while the lane bit is zero
    localparam LANES = 2;

    wire [LANES-1:0] lane_on;
    genvar lane;

    generate
        for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
            if (lane == 0) begin : g_first
                assign lane_on[lane] = 1'b1;
            end else begin : g_rest
                assign lane_on[lane] = ~ctrl[`CTRL_OUTPUT_LANE_BIT];
            end
        end
    endgenerate

    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_serial_out_first_en <= 1'b1;
            o_serial_out_second_en <= 1'b1;
        end else begin
            o_serial_out_first_en <= lane_on[0];
            o_serial_out_second_en <= lane_on[1];
        end
    end

    // ************************************************
    // Oversampling decode
    // ************************************************
    wire [2:0] osr_field = setup[`SETUP_OSR_HI:`SETUP_OSR_LO];
    wire osr_on = osr_active(osr_field);

    // ************************************************
    // Conversion mode outputs
    // ************************************************
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_width_boost_active <= 1'b0;
            o_reference_external <= 1'b0;
            o_shutdown <= 1'b0;
            o_oversample_enable <= 1'b0;
            o_oversample_ratio_field <= 3'h0;
        end else begin
            o_width_boost_active <= setup[`SETUP_WIDTH_BOOST_BIT] && osr_on;
            o_reference_external <= setup[`SETUP_REF_SOURCE_BIT];
            o_shutdown <= setup[`SETUP_POWER_DOWN_BIT];
            o_oversample_enable <= osr_on;
            o_oversample_ratio_field <= osr_field;
        end
    end

    // ************************************************
    // Reset command pulses
    // ************************************************
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_soft_reset <= 1'b0;
            o_hard_reset <= 1'b0;
        end else begin
            o_soft_reset <= soft_cmd;
            o_hard_reset <= hard_cmd;
        end
    end

    // ************************************************
    // Load status
    // ************************************************
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_config_busy <= 1'b1;
        end else begin
            o_config_busy <= load_busy;
        end
    end

endmodule // adc_config_fault_regs

//--- verification/adc_cfg_checker_assertions.sv
// Port assertions for the converter register bank
module adc_cfg_checker (
    // Clock, reset and register port
    input logic i_core_clk,
    input logic i_rst_n,
    input logic i_wr_valid,
    input logic [15:0] i_wr_word,
    input logic i_wr_check_ok,
    input logic i_rd_valid,
    input logic [3:0] i_rd_addr,
    input logic [15:0] o_rd_word,
    input logic o_rd_ready,
    // Configuration outputs
    input logic o_width_boost_active,
    input logic o_oversample_enable,
    input logic [2:0] o_oversample_ratio_field,
    input logic o_serial_out_first_en,
    input logic o_soft_reset,
    input logic o_hard_reset,
    input logic o_config_busy
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    AST_RD_READY: assert property (i_rd_valid |=> o_rd_ready)
        else $error("read not answered");
    AST_RD_ADDR: assert property (i_rd_valid |=> o_rd_word[15:12] == $past(i_rd_addr))
        else $error("read address not echoed");
    AST_BOOST: assert property (o_width_boost_active |-> o_oversample_enable)
        else $error("boost without oversampling");
    AST_OSR: assert property (o_oversample_enable == (o_oversample_ratio_field inside {[1:5]}))
        else $error("ratio decode wrong");
    AST_LANE: assert property (o_serial_out_first_en)
        else $error("first lane off");
    AST_SOFT: assert property (i_wr_valid && i_wr_check_ok && i_wr_word == 16'h203C |-> ##[1:2] o_soft_reset)
        else $error("soft reset missing");
    AST_HARD: assert property (i_wr_valid && i_wr_check_ok && i_wr_word == 16'h20FF |-> ##[1:2] o_hard_reset)
        else $error("hard reset missing");
    AST_NO_CMD: assert property (o_soft_reset |-> $past(i_wr_word) == 16'h203C || $past(i_wr_word, 2) == 16'h203C)
        else $error("spurious soft reset");
    AST_RELOAD: assert property (o_hard_reset |-> ##[0:2] o_config_busy)
        else $error("load not restarted");
    AST_RSVD: assert property (o_rd_ready && o_rd_word[15:12] == 4'h2 |-> o_rd_word[11:9] == 3'h0 && o_rd_word[7:0] == 8'h00)
        else $error("reserved bits not zero");
endmodule // adc_cfg_checker

bind adc_config_fault_regs adc_cfg_checker u_adc_cfg_checker (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_wr_valid(i_wr_valid), .i_wr_word(i_wr_word),
    .i_wr_check_ok(i_wr_check_ok), .i_rd_valid(i_rd_valid), .i_rd_addr(i_rd_addr),
    .o_rd_word(o_rd_word), .o_rd_ready(o_rd_ready), .o_width_boost_active(o_width_boost_active),
    .o_oversample_enable(o_oversample_enable), .o_oversample_ratio_field(o_oversample_ratio_field),
    .o_serial_out_first_en(o_serial_out_first_en), .o_soft_reset(o_soft_reset),
    .o_hard_reset(o_hard_reset), .o_config_busy(o_config_busy));

//--- verification/host_model.sv
// Host controller model on the register word port
module host_model (
    // Clock
    input logic i_core_clk,
    // Register word port
    output logic o_wr_valid,
    output logic [15:0] o_wr_word,
    output logic o_wr_check_ok,
    output logic o_rd_valid,
    output logic [3:0] o_rd_addr,
    input logic [15:0] i_rd_word,
    input logic i_rd_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_wr_valid = 1'b0;
        o_wr_word = 16'h0000;
        o_wr_check_ok = 1'b0;
        o_rd_valid = 1'b0;
        o_rd_addr = 4'h0;
    end
    task automatic wr(input logic [3:0] a, input logic [11:0] d, input logic ok);
        @(negedge i_core_clk);
        o_wr_valid = 1'b1;
        o_wr_word = {a, d};
        o_wr_check_ok = ok;
        @(negedge i_core_clk);
        o_wr_valid = 1'b0;
        o_wr_word = ~o_wr_word;
        o_wr_check_ok = ~ok;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] w, output logic rdy);
        @(negedge i_core_clk);
        o_rd_valid = 1'b1;
        o_rd_addr = a;
        @(negedge i_core_clk);
        o_rd_valid = 1'b0;
        o_rd_addr = ~a;
        w = i_rd_word;
        rdy = i_rd_ready;
    endtask
endmodule // host_model

//--- verification/test_adc_config_fault_regs.sv
// Self-checking bench for the converter register bank
module test_adc_config_fault_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, load_ok, wv, ck, rv, rrdy, rdy, en;
    logic boost, refx, sd, ose, sfirst, ssec, srst, hrst, busy;
    logic [15:0] ww, rw, got;
    logic [3:0] ra;
    logic [2:0] oversample_ratio_field;
    int error_cnt = 0;
    int n_compared = 0;
    int n_soft = 0;
    int n_hard = 0;
    host_model u_host_model (.i_core_clk(clk), .o_wr_valid(wv), .o_wr_word(ww),
        .o_wr_check_ok(ck), .o_rd_valid(rv), .o_rd_addr(ra), .i_rd_word(rw), .i_rd_ready(rrdy));
    adc_config_fault_regs #(.LOAD_CYCLES(8'h04)) u_adc_config_fault_regs (.i_core_clk(clk),
        .i_rst_n(rst_n), .i_wr_valid(wv), .i_wr_word(ww), .i_wr_check_ok(ck), .i_rd_valid(rv),
        .i_rd_addr(ra), .o_rd_word(rw), .o_rd_ready(rrdy), .i_load_ok(load_ok),
        .o_width_boost_active(boost), .o_reference_external(refx), .o_shutdown(sd),
        .o_oversample_enable(ose), .o_oversample_ratio_field(oversample_ratio_field), .o_serial_out_first_en(sfirst),
        .o_serial_out_second_en(ssec), .o_soft_reset(srst), .o_hard_reset(hrst),
        .o_config_busy(busy));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        u_host_model.rd(a, got, rdy);
        chk({15'h0000, rdy}, 16'h0001);
        chk(got, e);
    endtask
    // Command pulses last one cycle, so each spans exactly one falling edge
    always @(negedge clk) begin
        if (srst === 1'b1) begin
            n_soft++;
        end
        if (hrst === 1'b1) begin
            n_hard++;
        end
    end
    task automatic settle;
        repeat (3) @(negedge clk);
    endtask
    task automatic idle;
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
        chk({15'h0000, busy}, 16'h0000);
    endtask
    task automatic results;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #20000;
        error_cnt++;
        results;
    end
    initial begin
        rst_n = 1'b0;
        load_ok = 1'b1;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        idle;
        rdc(4'h2, 16'h2000);
        rdc(4'h3, 16'h3000);
        rdc(4'h7, 16'h7000);
        chk({14'h0000, sfirst, ssec}, 16'h0003);
        u_host_model.wr(4'h1, 12'hC07, 1'b1);
        settle;
        chk({12'h000, boost, refx, sd, ose}, 16'h0006);
        rdc(4'h1, 16'h1007);
        for (int c = 0; c < 8; c++) begin
            en = c > 0 && c < 6;
            u_host_model.wr(4'h1, {3'h0, c[2:0], 6'h04}, 1'b1);
            settle;
            chk({12'h000, ose, boost, refx, sd}, {12'h000, en, en, 2'b00});
            chk({13'h0000, oversample_ratio_field}, {13'h0000, c[2:0]});
        end
        u_host_model.wr(4'h2, 12'hF55, 1'b1);
        settle;
        chk({15'h0000, ssec}, 16'h0000);
        chk({n_soft[7:0], n_hard[7:0]}, 16'h0000);
        rdc(4'h2, 16'h2100);
        u_host_model.wr(4'h2, 12'h000, 1'b1);
        u_host_model.wr(4'h1, 12'h022, 1'b1);
        u_host_model.wr(4'h1, 12'h001, 1'b0);
        settle;
        chk({14'h0000, refx, sd}, 16'h0002);
        rdc(4'h3, 16'h3200);
        rdc(4'h3, 16'h3000);
        u_host_model.wr(4'h1, 12'h001, 1'b0);
        u_host_model.wr(4'h2, 12'h03C, 1'b1);
        settle;
        rdc(4'h3, 16'h3000);
        chk({n_soft[7:0], n_hard[7:0]}, 16'h0100);
        rdc(4'h1, 16'h1022);
        load_ok = 1'b0;
        u_host_model.wr(4'h2, 12'h0FF, 1'b1);
        settle;
        idle;
        rdc(4'h1, 16'h1000);
        chk({n_soft[7:0], n_hard[7:0]}, 16'h0101);
        rdc(4'h3, 16'h3100);
        rdc(4'h3, 16'h3100);
        load_ok = 1'b1;
        u_host_model.wr(4'h2, 12'h0FF, 1'b1);
        settle;
        idle;
        rdc(4'h3, 16'h3000);
        chk({n_soft[7:0], n_hard[7:0]}, 16'h0102);
        results;
    end
endmodule // test_adc_config_fault_regs
